// ===== hdl/maf_ctl.sv
// Switch controller: frame timing, lookup arbiter and forwarding decision
module maf_ctl #(
  parameter int NPORTS = 4,
  parameter int PW     = 2
) (
  // Link to table
  maf_if.ctl                      m,
  // Receive side
  input  wire logic               rx_pre_end,
  input  wire logic [PW-1:0]      rx_port,
  input  wire logic [47:0]        rx_da,
  input  wire logic [47:0]        rx_sa,
  input  wire logic [NPORTS-1:0]  port_enable,
  // Forwarding decision
  output logic                    fwd_valid,
  output logic                    fwd_match,
  output logic [NPORTS-1:0]       fwd_mask,
  // Host management
  input  wire logic               cfg_wr,
  input  wire logic               cfg_sync_first,
  input  wire logic               cpu_req,
  input  wire maf_pkg::maf_hp_op_t cpu_op,
  input  wire logic [14:0]        cpu_addr,
  input  wire logic [47:0]        cpu_key,
  input  wire logic [31:0]        cpu_wdata,
  output logic                    cpu_done,
  output logic                    cpu_valid,
  output logic [14:0]             cpu_index,
  output logic [47:0]             cpu_rkey,
  output logic [31:0]             cpu_rdata
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_SP   = 2'b01,
    C_HP   = 2'b10
  } maf_cst_t;

  typedef struct packed {
    maf_cst_t             st;
    logic [3:0]           cnt;
    logic                 on;
    logic                 da_p;
    logic                 sa_p;
    logic                 cpu_p;
    logic                 is_da;
    logic [PW-1:0]        port;
    logic                 sync_first;
    logic                 sp_req;
    maf_pkg::maf_sp_op_t  sp_op;
    logic [47:0]          sp_key;
    logic [31:0]          sp_data;
    logic                 hp_req;
    maf_pkg::maf_hp_op_t  hp_op;
    logic [14:0]          hp_addr;
    logic [47:0]          hp_key;
    logic [31:0]          hp_wdata;
    logic                 fwd_valid;
    logic                 fwd_match;
    logic [NPORTS-1:0]    fwd_mask;
    logic                 cpu_done;
    logic                 cpu_valid;
    logic [14:0]          cpu_index;
    logic [47:0]          cpu_rkey;
    logic [31:0]          cpu_rdata;
  } maf_ctl_st_t;

  maf_ctl_st_t s_reg;
  maf_ctl_st_t s_next;

  function automatic logic [NPORTS-1:0] onehot(input logic [PW-1:0] p);
    logic [NPORTS-1:0] r;
    r = '0;
    r[p] = 1'b1;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    s_next.fwd_valid = 1'b0;
    s_next.cpu_done  = 1'b0;
    if (cfg_wr) begin
      s_next.sync_first = cfg_sync_first;
    end
    if (cpu_req && !s_reg.cpu_p && !s_reg.cpu_done) begin
      s_next.cpu_p    = 1'b1;
      s_next.hp_op    = cpu_op;
      s_next.hp_addr  = cpu_addr;
      s_next.hp_key   = cpu_key;
      s_next.hp_wdata = cpu_wdata;
    end
    // Cycles since end of preamble; addresses are stable once counted
    if (rx_pre_end) begin
      s_next.on   = 1'b1;
      s_next.cnt  = 4'h1;
      s_next.port = rx_port;
    end else if (s_reg.on) begin
      s_next.cnt = s_reg.cnt + 4'h1;
      if (s_reg.cnt == 4'(maf_pkg::DA_CYC)) begin
        s_next.da_p = 1'b1;
      end
      if (s_reg.cnt == 4'(maf_pkg::SA_CYC)) begin
        s_next.sa_p = 1'b1;
        s_next.on   = 1'b0;
      end
    end
    case (s_reg.st)
      C_IDLE: begin
        // Destination first, then source, host management last
        if (s_reg.da_p) begin
          s_next.st     = C_SP;
          s_next.da_p   = 1'b0;
          s_next.is_da  = 1'b1;
          s_next.sp_req = 1'b1;
          s_next.sp_op  = maf_pkg::SP_SEARCH;
          s_next.sp_key = rx_da;
        end else if (s_reg.sa_p) begin
          s_next.st      = C_SP;
          s_next.sa_p    = 1'b0;
          s_next.is_da   = 1'b0;
          s_next.sp_req  = 1'b1;
          s_next.sp_op   = maf_pkg::SP_LEARN;
          s_next.sp_key  = rx_sa;
          s_next.sp_data = 32'(s_reg.port);
        end else if (s_reg.cpu_p) begin
          s_next.st     = C_HP;
          s_next.hp_req = 1'b1;
        end
      end
      C_SP: begin
        if (m.sp_ack) begin
          s_next.st     = C_IDLE;
          s_next.sp_req = 1'b0;
          if (s_reg.is_da) begin
            s_next.fwd_valid = 1'b1;
            // Broadcast is never a hit, even if the key was stored
            if (m.sp_hit && (s_reg.sp_key != maf_pkg::BCAST_KEY)) begin
              s_next.fwd_match = 1'b1;
              s_next.fwd_mask  = onehot(m.sp_rdata[PW-1:0]) & ~onehot(s_reg.port);
            end else begin
              s_next.fwd_match = 1'b0;
              s_next.fwd_mask  = port_enable & ~onehot(s_reg.port);
            end
          end
        end
      end
      C_HP: begin
        if (m.hp_ack) begin
          s_next.st        = C_IDLE;
          s_next.hp_req    = 1'b0;
          s_next.cpu_p     = 1'b0;
          s_next.cpu_done  = 1'b1;
          s_next.cpu_valid = m.hp_valid;
          s_next.cpu_index = m.hp_index;
          s_next.cpu_rkey  = m.hp_rkey;
          s_next.cpu_rdata = m.hp_rdata;
        end
      end
      default: begin
        s_next.st = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge m.core_clk) begin
    if (m.reset) begin
      s_reg            <= '0;
      s_reg.sync_first <= maf_pkg::SYNC_FIRST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign m.sp_req     = s_reg.sp_req;
  assign m.sp_op      = s_reg.sp_op;
  assign m.sp_key     = s_reg.sp_key;
  assign m.sp_data    = s_reg.sp_data;
  assign m.hp_req     = s_reg.hp_req;
  assign m.hp_op      = s_reg.hp_op;
  assign m.hp_addr    = s_reg.hp_addr;
  assign m.hp_key     = s_reg.hp_key;
  assign m.hp_wdata   = s_reg.hp_wdata;
  assign m.sync_first = s_reg.sync_first;
  assign fwd_valid    = s_reg.fwd_valid;
  assign fwd_match    = s_reg.fwd_match;
  assign fwd_mask     = s_reg.fwd_mask;
  assign cpu_done     = s_reg.cpu_done;
  assign cpu_valid    = s_reg.cpu_valid;
  assign cpu_index    = s_reg.cpu_index;
  assign cpu_rkey     = s_reg.cpu_rkey;
  assign cpu_rdata    = s_reg.cpu_rdata;
endmodule

// ===== hdl/maf_if.sv
// Link between the table device and its controller
interface maf_if (
  input wire logic core_clk,
  input wire logic reset
);
  // Synchronous port
  logic                          sp_req;
  maf_pkg::maf_sp_op_t           sp_op;
  logic [maf_pkg::KEY_W-1:0]     sp_key;
  logic [maf_pkg::DATA_W-1:0]    sp_data;
  logic                          sp_ack;
  logic                          sp_hit;
  logic [maf_pkg::IDX_W-1:0]     sp_index;
  logic [maf_pkg::DATA_W-1:0]    sp_rdata;
  // Processor port
  logic                          hp_req;
  maf_pkg::maf_hp_op_t           hp_op;
  logic [maf_pkg::IDX_W-1:0]     hp_addr;
  logic [maf_pkg::KEY_W-1:0]     hp_key;
  logic [maf_pkg::DATA_W-1:0]    hp_wdata;
  logic                          hp_ack;
  logic                          hp_valid;
  logic [maf_pkg::IDX_W-1:0]     hp_index;
  logic [maf_pkg::KEY_W-1:0]     hp_rkey;
  logic [maf_pkg::DATA_W-1:0]    hp_rdata;
  // Configuration and flags
  logic                          sync_first;
  logic                          table_full_flag_n;

  modport dev (
    input  core_clk, reset, sp_req, sp_op, sp_key, sp_data, hp_req, hp_op, hp_addr,
           hp_key, hp_wdata, sync_first,
    output sp_ack, sp_hit, sp_index, sp_rdata, hp_ack, hp_valid, hp_index, hp_rkey,
           hp_rdata, table_full_flag_n
  );
  modport ctl (
    input  core_clk, reset, sp_ack, sp_hit, sp_index, sp_rdata, hp_ack, hp_valid,
           hp_index, hp_rkey, hp_rdata, table_full_flag_n,
    output sp_req, sp_op, sp_key, sp_data, hp_req, hp_op, hp_addr, hp_key, hp_wdata,
           sync_first
  );
endinterface

// ===== hdl/maf_pkg.sv
// Shared constants and types for the MAC address filter table and its controller
// Function
// - Key compared against all entries in parallel
// - Device finds next free slot itself
// - Entry is 48-bit key plus 32-bit data
// - Depths cascade to one table, 32K max
// - Both ports concurrent; priority port wins ties
// - Port priority is configured, sync port first
// - Automatic time stamps and aging out
// - Queues of recently aged and learned entries
// - Report index of the matched entry
// - Controller looks up source, learns or refreshes
// - Controller ranks destination, source, then host
// - Destination hit forwards to stored port unless it is the ingress
// - Miss or broadcast floods enabled ports but ingress
// - Lookups issued at 480 and 960 ns
// - One search plus learn per packet sustained
// - Search plus learn within seven clocks
// - Active-low full flag when no free slot
package maf_pkg;
  localparam int KEY_W         = 48;
  localparam int DATA_W        = 32;
  localparam int ENTRY_W       = KEY_W + DATA_W;
  localparam int IDX_W         = 15;
  localparam int STAMP_W       = 8;
  localparam int QUEUE_DEPTH   = 4;
  localparam int QCNT_W        = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int DA_TIME_NS    = 480;
  localparam int SA_TIME_NS    = 960;
  localparam int DA_CYC        = (DA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SA_CYC        = (SA_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAIR_MAX_CYC  = 7;
  localparam logic [KEY_W-1:0] BCAST_KEY = 48'hffff_ffff_ffff;
  localparam logic             SYNC_FIRST_RST = 1'h1;

  typedef enum logic [0:0] {
    SP_SEARCH = 1'b0,
    SP_LEARN  = 1'b1
  } maf_sp_op_t;

  typedef enum logic [2:0] {
    HP_READ     = 3'b000,
    HP_WRITE    = 3'b001,
    HP_DELETE   = 3'b010,
    HP_POP_AGED = 3'b011,
    HP_POP_LRND = 3'b100
  } maf_hp_op_t;
endpackage

// ===== hdl/maf_table.sv
// Content-addressed forwarding table with learning, aging and event queues
module maf_table #(
  parameter int          DEPTH        = 2048,
  parameter int          BASE         = 0,
  parameter int          AGE_TICK_CYC = 10000000,
  parameter logic [7:0]  AGE_LIMIT    = 8'h96
) (
  // Link to controller
  maf_if.dev             m
);
  localparam int AW = $clog2(DEPTH);
  localparam int QD = maf_pkg::QUEUE_DEPTH;

  typedef logic [QD-1:0][maf_pkg::IDX_W-1:0] maf_q_t;

  typedef struct packed {
    logic [31:0]                  tick;
    logic [maf_pkg::STAMP_W-1:0]  now;
    logic [AW-1:0]                sweep;
    logic                         sp_ack;
    logic                         sp_hit;
    logic [maf_pkg::IDX_W-1:0]    sp_index;
    logic [maf_pkg::DATA_W-1:0]   sp_rdata;
    logic                         hp_ack;
    logic                         hp_valid;
    logic [maf_pkg::IDX_W-1:0]    hp_index;
    logic [maf_pkg::KEY_W-1:0]    hp_rkey;
    logic [maf_pkg::DATA_W-1:0]   hp_rdata;
    maf_q_t                       aged_q;
    logic [maf_pkg::QCNT_W-1:0]   aged_n;
    maf_q_t                       lrn_q;
    logic [maf_pkg::QCNT_W-1:0]   lrn_n;
    logic                         full_n;
  } maf_tbl_st_t;

  maf_tbl_st_t s_reg;
  maf_tbl_st_t s_next;

  // Table storage
  logic [maf_pkg::KEY_W-1:0]   key_mem [DEPTH];
  logic [maf_pkg::DATA_W-1:0]  dat_mem [DEPTH];
  logic [maf_pkg::STAMP_W-1:0] stp_mem [DEPTH];
  logic [DEPTH-1:0]            vld_reg;

  // Single table write port shared by both ports and the aging sweep
  logic                        mw_en;
  logic                        mw_vld;
  logic [AW-1:0]               mw_idx;
  logic [maf_pkg::KEY_W-1:0]   mw_key;
  logic [maf_pkg::DATA_W-1:0]  mw_dat;

  logic [DEPTH-1:0]            hitv;
  logic [AW:0]                 hit;
  logic [AW:0]                 free;
  logic                        sp_go;
  logic                        hp_go;
  logic [AW-1:0]               hp_loc;

  // Lowest set bit: found flag on top, index below
  function automatic logic [AW:0] first_set(input logic [DEPTH-1:0] v);
    logic [AW:0] r;
    r = '0;
    for (int i = DEPTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, AW'(i)};
      end
    end
    return r;
  endfunction

  function automatic maf_q_t q_shift(input maf_q_t q);
    maf_q_t r;
    r = '0;
    for (int i = 0; i < QD - 1; i++) begin
      r[i] = q[i+1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel compare of the key against every entry, no scan
  generate
    for (genvar g = 0; g < DEPTH; g++) begin : g_cmp
      assign hitv[g] = vld_reg[g] && (key_mem[g] == m.sp_key);
    end
  endgenerate

  assign hit    = first_set(hitv);
  assign free   = first_set(~vld_reg);
  assign hp_loc = m.hp_addr[AW-1:0];

  // Grants; a port whose answer is showing is idle for that cycle
  always_comb begin
    hp_go = m.hp_req && !s_reg.hp_ack;
    sp_go = m.sp_req && !s_reg.sp_ack && (m.sync_first || !hp_go);
    hp_go = hp_go && !sp_go;
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next   = s_reg;
    mw_en    = 1'b0;
    mw_vld   = 1'b1;
    mw_idx   = '0;
    mw_key   = m.sp_key;
    mw_dat   = m.sp_data;
    s_next.sp_ack = 1'b0;
    s_next.hp_ack = 1'b0;
    // Stamp clock; stamps wrap, so the limit must stay below the wrap
    if (s_reg.tick == 32'(AGE_TICK_CYC - 1)) begin
      s_next.tick = '0;
      s_next.now  = s_reg.now + 8'h01;
    end else begin
      s_next.tick = s_reg.tick + 32'h1;
    end
    if (sp_go) begin
      // Every operation finishes in one cycle, well inside seven
      s_next.sp_ack   = 1'b1;
      s_next.sp_hit   = hit[AW];
      s_next.sp_index = maf_pkg::IDX_W'(BASE) + maf_pkg::IDX_W'(hit[AW-1:0]);
      s_next.sp_rdata = hit[AW] ? dat_mem[hit[AW-1:0]] : '0;
      if (m.sp_op == maf_pkg::SP_LEARN) begin
        if (hit[AW]) begin
          mw_en  = 1'b1; // Refresh stamp and port of a known address
          mw_idx = hit[AW-1:0];
        end else if (free[AW]) begin
          mw_en  = 1'b1;
          mw_idx = free[AW-1:0];
          s_next.sp_index = maf_pkg::IDX_W'(BASE) + maf_pkg::IDX_W'(free[AW-1:0]);
          if (s_reg.lrn_n != QD[maf_pkg::QCNT_W-1:0]) begin
            s_next.lrn_q[s_reg.lrn_n] = s_next.sp_index;
            s_next.lrn_n = s_reg.lrn_n + 3'h1;
          end
        end
      end
    end else if (hp_go) begin
      s_next.hp_ack   = 1'b1;
      s_next.hp_valid = 1'b1;
      s_next.hp_index = m.hp_addr;
      mw_key = m.hp_key;
      mw_dat = m.hp_wdata;
      mw_idx = hp_loc;
      case (m.hp_op)
        maf_pkg::HP_READ: begin
          s_next.hp_valid = vld_reg[hp_loc];
          s_next.hp_rkey  = key_mem[hp_loc];
          s_next.hp_rdata = dat_mem[hp_loc];
        end
        maf_pkg::HP_WRITE: begin
          mw_en = 1'b1;
        end
        maf_pkg::HP_DELETE: begin
          mw_en  = 1'b1;
          mw_vld = 1'b0;
        end
        maf_pkg::HP_POP_AGED: begin
          s_next.hp_valid = (s_reg.aged_n != '0);
          s_next.hp_index = s_reg.aged_q[0];
          if (s_reg.aged_n != '0) begin
            s_next.aged_q = q_shift(s_reg.aged_q);
            s_next.aged_n = s_reg.aged_n - 3'h1;
          end
        end
        maf_pkg::HP_POP_LRND: begin
          s_next.hp_valid = (s_reg.lrn_n != '0);
          s_next.hp_index = s_reg.lrn_q[0];
          if (s_reg.lrn_n != '0) begin
            s_next.lrn_q = q_shift(s_reg.lrn_q);
            s_next.lrn_n = s_reg.lrn_n - 3'h1;
          end
        end
        default: begin
          s_next.hp_valid = 1'b0;
        end
      endcase
    end
    // Aging sweep borrows the write port only when no port uses it
    if (!mw_en) begin
      s_next.sweep = s_reg.sweep + AW'(1);
      if (vld_reg[s_reg.sweep] && ((s_reg.now - stp_mem[s_reg.sweep]) > AGE_LIMIT)) begin
        mw_en  = 1'b1;
        mw_vld = 1'b0;
        mw_idx = s_reg.sweep;
        mw_key = key_mem[s_reg.sweep];
        mw_dat = dat_mem[s_reg.sweep];
        if (s_next.aged_n != QD[maf_pkg::QCNT_W-1:0]) begin
          s_next.aged_q[s_next.aged_n] =
            maf_pkg::IDX_W'(BASE) + maf_pkg::IDX_W'(s_reg.sweep);
          s_next.aged_n = s_next.aged_n + 3'h1;
        end
      end
    end
    // Reflects occupancy as of this edge, so it trails a fill by one cycle
    s_next.full_n = free[AW];
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge m.core_clk) begin
    if (m.reset) begin
      s_reg        <= '0;
      s_reg.full_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge m.core_clk) begin
    if (m.reset) begin
      vld_reg <= '0;
    end else if (mw_en) begin
      vld_reg[mw_idx] <= mw_vld;
    end
  end

  // Storage needs no reset: the valid bits guard every entry
  always_ff @(posedge m.core_clk) begin
    if (mw_en) begin
      key_mem[mw_idx] <= mw_key;
      dat_mem[mw_idx] <= mw_dat;
      stp_mem[mw_idx] <= s_reg.now;
    end
  end

  assign m.sp_ack            = s_reg.sp_ack;
  assign m.sp_hit            = s_reg.sp_hit;
  assign m.sp_index          = s_reg.sp_index;
  assign m.sp_rdata          = s_reg.sp_rdata;
  assign m.hp_ack            = s_reg.hp_ack;
  assign m.hp_valid          = s_reg.hp_valid;
  assign m.hp_index          = s_reg.hp_index;
  assign m.hp_rkey           = s_reg.hp_rkey;
  assign m.hp_rdata          = s_reg.hp_rdata;
  assign m.table_full_flag_n = s_reg.full_n;
endmodule

// ===== tb/mac_address_filter_table_test.sv
// Self-checking bench for the table and controller joined over their link
module mac_address_filter_table_test;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int          DEPTH  = 4;
  localparam logic [47:0] NODE_A = 48'h02aa_0000_0001;
  localparam logic [47:0] NODE_C = 48'h02aa_0000_0003;
  localparam logic [47:0] NODE_D = 48'h02aa_0000_0004;
  localparam logic [47:0] NODE_E = 48'h02aa_0000_0005;
  localparam logic [47:0] NODE_F = 48'h02aa_0000_0006;
  localparam logic [47:0] NODE_X = 48'h02aa_0000_0099;

  logic                core_clk;
  logic                reset;
  logic                rx_pre_end;
  logic [1:0]          rx_port;
  logic [47:0]         rx_da;
  logic [47:0]         rx_sa;
  logic [3:0]          port_enable;
  logic                fwd_valid;
  logic                fwd_match;
  logic [3:0]          fwd_mask;
  logic                cfg_wr;
  logic                cfg_sync_first;
  logic                cpu_req;
  maf_pkg::maf_hp_op_t cpu_op;
  logic [14:0]         cpu_addr;
  logic [47:0]         cpu_key;
  logic [31:0]         cpu_wdata;
  logic                cpu_done;
  logic                cpu_valid;
  logic [14:0]         cpu_index;
  logic [47:0]         cpu_rkey;
  logic [31:0]         cpu_rdata;
  logic [14:0]         slot_a;
  int                  err_count;
  int                  n_tests;

  ////////////////////////////////////////////////////////////
  // Design, link and checker
  maf_if link (.core_clk(core_clk), .reset(reset));
  // Short age tick keeps the aging scenario within a few hundred cycles
  maf_table #(.DEPTH(DEPTH), .AGE_TICK_CYC(4)) u_maf_table (
    .m(link.dev));
  maf_ctl #(.NPORTS(4), .PW(2)) u_maf_ctl (
    .m(link.ctl), .rx_pre_end(rx_pre_end), .rx_port(rx_port), .rx_da(rx_da),
    .rx_sa(rx_sa), .port_enable(port_enable), .fwd_valid(fwd_valid),
    .fwd_match(fwd_match), .fwd_mask(fwd_mask), .cfg_wr(cfg_wr),
    .cfg_sync_first(cfg_sync_first), .cpu_req(cpu_req), .cpu_op(cpu_op),
    .cpu_addr(cpu_addr), .cpu_key(cpu_key), .cpu_wdata(cpu_wdata), .cpu_done(cpu_done),
    .cpu_valid(cpu_valid), .cpu_index(cpu_index), .cpu_rkey(cpu_rkey),
    .cpu_rdata(cpu_rdata));
  maf_link_props #(.DEPTH(DEPTH)) chk (
    .core_clk(core_clk), .reset(reset), .sp_req(link.sp_req), .sp_op(link.sp_op),
    .sp_key(link.sp_key), .sp_ack(link.sp_ack), .sp_hit(link.sp_hit),
    .sp_index(link.sp_index), .sp_rdata(link.sp_rdata), .hp_req(link.hp_req),
    .hp_ack(link.hp_ack), .sync_first(link.sync_first),
    .table_full_flag_n(link.table_full_flag_n));

  initial core_clk = 1'h0;
  always #50 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Returns cycles from the start-of-frame edge to the decision; it does not wait
  // for the source lookup, which the caller lets finish before the next frame
  task automatic send_frame(input logic [1:0] p, input logic [47:0] da,
                            input logic [47:0] sa, output int lat);
    rx_port    = p;
    rx_da      = da;
    rx_sa      = sa;
    rx_pre_end = 1'h1;
    tick();
    rx_pre_end = 1'h0;
    lat        = 0;
    while (fwd_valid !== 1'h1 && lat < 40) begin
      tick();
      lat++;
    end
  endtask

  task automatic frame(input logic [1:0] p, input logic [47:0] da, input logic [47:0] sa,
                       input logic m_exp, input logic [3:0] mask_exp);
    int lat;
    send_frame(p, da, sa, lat);
    check(lat, maf_pkg::DA_CYC + 3);
    check(fwd_match, m_exp);
    check(fwd_mask, mask_exp);
    repeat (25) tick();
  endtask

  task automatic cpu_call(input maf_pkg::maf_hp_op_t op, input logic [14:0] addr);
    int n;
    tick();
    cpu_op   = op;
    cpu_addr = addr;
    cpu_req  = 1'h1;
    n        = 0;
    while (cpu_done !== 1'h1 && n < 20) begin
      tick();
      n++;
    end
    cpu_req = 1'h0;
    check(cpu_done, 1'h1);
  endtask

  ////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_flood_learn();
    frame(2'h1, NODE_X, NODE_A, 1'h0, 4'h9);
    cpu_call(maf_pkg::HP_POP_LRND, 15'h0000);
    check(cpu_valid, 1'h1);
    check(cpu_index, 15'h0000);
    slot_a = cpu_index;
    cpu_call(maf_pkg::HP_READ, slot_a);
    check(cpu_rkey, NODE_A);
    check(cpu_rdata[1:0], 2'h1);
  endtask

  task automatic t_hits();
    frame(2'h2, NODE_A, NODE_C, 1'h1, 4'h2);
    frame(2'h1, NODE_A, NODE_A, 1'h1, 4'h0);
  endtask

  task automatic t_bcast();
    frame(2'h3, maf_pkg::BCAST_KEY, NODE_D, 1'h0, 4'h3);
    check(link.table_full_flag_n, 1'h1);
  endtask

  task automatic t_full();
    frame(2'h0, NODE_C, NODE_E, 1'h1, 4'h4);
    check(link.table_full_flag_n, 1'h0);
    frame(2'h0, NODE_X, NODE_F, 1'h0, 4'ha);
    frame(2'h1, NODE_F, NODE_E, 1'h0, 4'h9);
  endtask

  task automatic t_host();
    cfg_sync_first = 1'h0;
    cfg_wr         = 1'h1;
    tick();
    cfg_wr = 1'h0;
    tick();
    check(link.sync_first, 1'h0);
    cpu_call(maf_pkg::HP_DELETE, slot_a);
    repeat (3) tick();
    check(link.table_full_flag_n, 1'h1);
    cpu_call(maf_pkg::HP_READ, slot_a);
    check(cpu_valid, 1'h0);
    cpu_key   = NODE_F;
    cpu_wdata = 32'h0000_0003;
    cpu_call(maf_pkg::HP_WRITE, slot_a);
    frame(2'h0, NODE_F, NODE_E, 1'h1, 4'h8);
    cfg_sync_first = 1'h1;
    cfg_wr         = 1'h1;
    tick();
    cfg_wr = 1'h0;
    tick();
    check(link.sync_first, 1'h1);
  endtask

  // Nothing refreshes the entries here, so every one must time out
  task automatic t_aging();
    repeat (900) tick();
    cpu_call(maf_pkg::HP_POP_AGED, 15'h0000);
    check(cpu_valid, 1'h1);
    // Slot 1 holds the oldest stamp, so it is the first to age out
    check(cpu_index, 15'h0001);
    frame(2'h0, NODE_C, NODE_D, 1'h0, 4'ha);
  endtask

  ////////////////////////////////////////////////////////////
  // Run control
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    complete_run();
  end

  initial begin
    err_count      = 0;
    n_tests        = 0;
    reset          = 1'h1;
    rx_pre_end     = 1'h0;
    rx_port        = 2'h0;
    rx_da          = 48'h0;
    rx_sa          = 48'h0;
    port_enable    = 4'hb;
    cfg_wr         = 1'h0;
    cfg_sync_first = 1'h1;
    cpu_req        = 1'h0;
    cpu_op         = maf_pkg::HP_READ;
    cpu_addr       = 15'h0000;
    cpu_key        = 48'h0;
    cpu_wdata      = 32'h0;
    slot_a         = 15'h0000;
    repeat (4) @(posedge core_clk);
    #1;
    reset = 1'h0;
    t_flood_learn();
    t_hits();
    t_bcast();
    t_full();
    t_host();
    t_aging();
    complete_run();
  end
endmodule

// ===== tb/maf_link_props.sv
// Checker watching the link between the table and its controller
module maf_link_props #(
  parameter int DEPTH = 4,
  parameter int BASE  = 0
) (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       reset,
  // Synchronous port
  input wire logic                       sp_req,
  input wire maf_pkg::maf_sp_op_t        sp_op,
  input wire logic [maf_pkg::KEY_W-1:0]  sp_key,
  input wire logic                       sp_ack,
  input wire logic                       sp_hit,
  input wire logic [maf_pkg::IDX_W-1:0]  sp_index,
  input wire logic [maf_pkg::DATA_W-1:0] sp_rdata,
  // Processor port and flags
  input wire logic                       hp_req,
  input wire logic                       hp_ack,
  input wire logic                       sync_first,
  input wire logic                       table_full_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////
  // Arbitration between the two ports
  a_sp_taken: assert property (
    sp_req && !sp_ack && (sync_first || !hp_req || hp_ack) |=> sp_ack)
    else $error("sync request not served in the next cycle");
  a_hp_taken: assert property (
    hp_req && !hp_ack && (!sync_first || !sp_req || sp_ack) |=> hp_ack)
    else $error("host request not served in the next cycle");
  a_sp_ack_cause: assert property (
    sp_ack |-> $past(sp_req) && !$past(sp_ack))
    else $error("sync answer without a pending request");
  a_hp_ack_cause: assert property (
    hp_ack |-> $past(hp_req) && !$past(hp_ack))
    else $error("host answer without a pending request");

  ////////////////////////////////////////////////////////////
  // Controller request discipline
  a_req_held: assert property (
    sp_req && !sp_ack |=> sp_req && $stable(sp_key) && $stable(sp_op))
    else $error("sync request changed before its answer");
  a_req_drop: assert property (
    sp_ack |=> !sp_req)
    else $error("sync request not released after answer");

  ////////////////////////////////////////////////////////////
  // Answer contents and the full flag
  a_hit_index: assert property (
    sp_ack && sp_hit |-> sp_index >= BASE && sp_index < BASE + DEPTH)
    else $error("hit index outside this table");
  a_miss_zero: assert property (
    sp_ack && !sp_hit |-> sp_rdata == '0)
    else $error("miss returned nonzero data");
  // Flag trails occupancy, so allow one or two cycles after the write
  a_full_cause: assert property (
    $fell(table_full_flag_n) |-> $past(sp_ack) || $past(hp_ack)
                                 || $past(sp_ack, 2) || $past(hp_ack, 2))
    else $error("full flag fell without a table write");
endmodule
